// ==== dpm_arbiter.sv ====
// Purpose: dual-port memory with refresh-first port arbitration
// Assumes: address, data, write and byte enables stable while a request
//   is high; request pins held until acknowledged
// Notes: storage is flip-flops; depth sets the fitted capacity
// Functional notes
// R1 - two independent ports, each with its own address, data and control.
// R2 - on simultaneous requests port B is granted first and port A waits.
// R3 - port A may assert lock to keep port B from being granted.
// R4 - port order only picks which port goes next, not cycle ranking.
// R5 - a due refresh is performed before any port access.
// R6 - refresh recurs on a fixed period so no data is ever lost.
// R7 - words are two bytes, with an optional parity bit per byte.
// R8 - each byte of a word may be written without altering the other.
// R9 - capacity is 16K, 32K or 64K words and decode matches it.
// R10 - a cycle ends within 660 ns and read data within 560 ns.
// R11 - requests come from the backplane, or from dedicated map lines.
// R12 - with error correction, backplane is ignored, board paces refresh.
// R13 - with error correction, the board relays acknowledge to the CPU.
// R14 - a request losing arbitration stays pending and is served later.
`timescale 1ns/100ps
module dpm_arbiter
  import dpm_pkg::*;
#(
  parameter int DEPTH = FULL_WORDS,
  parameter bit PARITY_EN = 1'b1,
  parameter int REFRESH_CYCLES = REFRESH_PERIOD_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic a_req_bp,
  input wire logic a_req_link,
  input wire logic a_we,
  input wire logic [LANES-1:0] a_be,
  input wire logic [ADDR_W-1:0] a_addr,
  input wire logic [DATA_W-1:0] a_wdata,
  output logic [WORD_W-1:0] a_rdata,
  output logic a_ack,
  input wire logic b_req_bp,
  input wire logic b_req_link,
  input wire logic b_we,
  input wire logic [LANES-1:0] b_be,
  input wire logic [ADDR_W-1:0] b_addr,
  input wire logic [DATA_W-1:0] b_wdata,
  output logic [WORD_W-1:0] b_rdata,
  output logic b_ack,
  input wire logic a_lock,
  input wire logic ecc_mode,
  input wire logic map_ext,
  input wire logic ecc_refresh_req,
  output logic refresh_busy
);

  localparam int IDX_W = $clog2(DEPTH);
  localparam int ACC_N = ACCESS_CYC;
  localparam int DUE_MAX = ACCESS_CYC + 2;
  localparam int BUS_W = 2 * (1 + LANES + ADDR_W + DATA_W);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [SYNC_W-1:0] raw_in, s_in;
  logic [BUS_W-1:0] raw_bus, s_bus;
  logic a_we_s, b_we_s;
  logic [LANES-1:0] a_be_s, b_be_s;
  logic [ADDR_W-1:0] a_addr_s, b_addr_s;
  logic [DATA_W-1:0] a_wdata_s, b_wdata_s;
  assign raw_in = {ecc_refresh_req, map_ext, ecc_mode, a_lock,
                   b_req_link, b_req_bp, a_req_link, a_req_bp};
  // bus lines take the same two flops, so they line up with the request
  assign raw_bus = {a_we, a_be, a_addr, a_wdata,
                    b_we, b_be, b_addr, b_wdata};
  assign {a_we_s, a_be_s, a_addr_s, a_wdata_s,
          b_we_s, b_be_s, b_addr_s, b_wdata_s} = s_bus;
  dpm_sync #(.WIDTH(SYNC_W)) u_sync (.clk(clk), .srst(srst), .din(raw_in),
    .dout(s_in));
  dpm_sync #(.WIDTH(BUS_W)) u_sync_bus (.clk(clk), .srst(srst),
    .din(raw_bus), .dout(s_bus));

  // ************************************************************
  // request source and address decode
  // ************************************************************
  logic use_link, a_req_sel, b_req_sel, a_addr_ok, b_addr_ok;
  logic pend_a, pend_b, grant_a, grant_b, s_lock;
  always_comb begin
    // ecc or extended map: dedicated lines, backplane ignored
    use_link = s_in[SI_ECC] | s_in[SI_MAP]; // [R11] [R12]
    a_req_sel = use_link ? s_in[SI_A_LINK] : s_in[SI_A_BP]; // [R1]
    b_req_sel = use_link ? s_in[SI_B_LINK] : s_in[SI_B_BP]; // [R1]
    // depopulated module answers only inside its fitted range
    a_addr_ok = {1'b0, a_addr_s} < (ADDR_W+1)'(DEPTH); // [R9]
    b_addr_ok = {1'b0, b_addr_s} < (ADDR_W+1)'(DEPTH); // [R9]
    s_lock = s_in[SI_LOCK];
  end
  dpm_port_req u_port_a (.clk(clk), .srst(srst), .req(a_req_sel),
    .addr_ok(a_addr_ok), .grant(grant_a), .pending(pend_a));
  dpm_port_req u_port_b (.clk(clk), .srst(srst), .req(b_req_sel),
    .addr_ok(b_addr_ok), .grant(grant_b), .pending(pend_b));

  // ************************************************************
  // refresh scheduling
  // ************************************************************
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic due_reg, due_next, eref_q_reg, eref_q_next, tick, ref_start;
  always_comb begin
    tmr_next = tmr_reg + TMR_W'(1);
    tick = 1'b0;
    if (tmr_reg == TMR_W'(REFRESH_CYCLES - 1)) begin
      tmr_next = '0;
    end
    eref_q_next = s_in[SI_EREF];
    if (s_in[SI_ECC]) begin
      // board aligns refresh with its own cycles
      tick = s_in[SI_EREF] & ~eref_q_reg; // [R12]
    end else begin
      tick = (tmr_reg == TMR_W'(REFRESH_CYCLES - 1)); // [R6]
    end
    // a fresh tick beats the clear of the one being served
    due_next = tick | (due_reg & ~ref_start); // [R6]
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      tmr_reg <= '0;
      due_reg <= 1'b0;
      eref_q_reg <= 1'b0;
    end else begin
      tmr_reg <= tmr_next;
      due_reg <= due_next;
      eref_q_reg <= eref_q_next;
    end
  end

  // ************************************************************
  // cycle sequencer
  // ************************************************************
  dpm_state_t state_reg, state_next;
  dpm_port_t sel_reg, sel_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [ADDR_W-1:0] op_addr_reg, op_addr_next;
  logic op_we_reg, op_we_next, mem_we, finish;
  logic [LANES-1:0] op_be_reg, op_be_next;
  logic [DATA_W-1:0] op_wdata_reg, op_wdata_next;
  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    cnt_next = cnt_reg;
    op_addr_next = op_addr_reg;
    op_we_next = op_we_reg;
    op_be_next = op_be_reg;
    op_wdata_next = op_wdata_reg;
    grant_a = 1'b0;
    grant_b = 1'b0;
    ref_start = 1'b0;
    mem_we = 1'b0;
    finish = 1'b0;
    case (state_reg)
      DPM_IDLE: begin
        // port choice lives here, after the refresh check that ranks above it
        if (due_reg) begin
          ref_start = 1'b1; // [R5]
          state_next = DPM_REFRESH;
          cnt_next = CNT_W'(REFRESH_CYC - 1);
        end else if (pend_b && !s_lock) begin
          grant_b = 1'b1; // [R2] [R4]
          sel_next = DPM_PORT_B;
          state_next = DPM_ACCESS;
          cnt_next = CNT_W'(ACCESS_CYC - 1);
          op_addr_next = b_addr_s;
          op_we_next = b_we_s;
          op_be_next = b_be_s;
          op_wdata_next = b_wdata_s;
        end else if (pend_a) begin
          grant_a = 1'b1; // [R3] [R4]
          sel_next = DPM_PORT_A;
          state_next = DPM_ACCESS;
          cnt_next = CNT_W'(ACCESS_CYC - 1);
          op_addr_next = a_addr_s;
          op_we_next = a_we_s;
          op_be_next = a_be_s;
          op_wdata_next = a_wdata_s;
        end
      end
      DPM_ACCESS: begin
        cnt_next = cnt_reg - CNT_W'(1);
        if (cnt_reg == '0) begin
          finish = 1'b1; // [R10]
          mem_we = op_we_reg;
          state_next = DPM_IDLE;
        end
      end
      DPM_REFRESH: begin
        cnt_next = cnt_reg - CNT_W'(1);
        if (cnt_reg == '0) begin
          state_next = DPM_IDLE;
        end
      end
      default: begin
        state_next = DPM_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= DPM_IDLE;
      sel_reg <= DPM_PORT_A;
      cnt_reg <= '0;
      op_addr_reg <= '0;
      op_we_reg <= 1'b0;
      op_be_reg <= '0;
      op_wdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      cnt_reg <= cnt_next;
      op_addr_reg <= op_addr_next;
      op_we_reg <= op_we_next;
      op_be_reg <= op_be_next;
      op_wdata_reg <= op_wdata_next;
    end
  end

  // ************************************************************
  // storage and answers
  // ************************************************************
  // flip-flop array: fine for models, costly at full depth
  logic [WORD_W-1:0] mem_reg [DEPTH];
  logic [IDX_W-1:0] idx;
  logic [WORD_W-1:0] mem_cur, wr_word, rd_word;
  logic [WORD_W-1:0] a_rdata_reg, a_rdata_next, b_rdata_reg, b_rdata_next;
  logic a_ack_reg, a_ack_next, b_ack_reg, b_ack_next, busy_reg, busy_next;
  always_comb begin
    idx = op_addr_reg[IDX_W-1:0];
    mem_cur = mem_reg[idx];
    wr_word = mem_cur;
    rd_word = mem_cur;
    for (int i = 0; i < LANES; i++) begin
      if (op_be_reg[i]) begin
        // untouched lane keeps its old byte and parity
        wr_word[i*BYTE_W +: BYTE_W] = op_wdata_reg[i*BYTE_W +: BYTE_W]; // [R8]
        wr_word[DATA_W + i] = PARITY_EN &
                              (^op_wdata_reg[i*BYTE_W +: BYTE_W]); // [R7]
      end
    end
    if (!PARITY_EN) begin
      rd_word[WORD_W-1:DATA_W] = '0; // [R7]
    end
    a_rdata_next = a_rdata_reg;
    b_rdata_next = b_rdata_reg;
    a_ack_next = finish && (sel_reg == DPM_PORT_A); // [R13]
    b_ack_next = finish && (sel_reg == DPM_PORT_B); // [R13]
    if (a_ack_next && !op_we_reg) begin
      a_rdata_next = rd_word;
    end
    if (b_ack_next && !op_we_reg) begin
      b_rdata_next = rd_word;
    end
    busy_next = (state_next == DPM_REFRESH);
  end
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_reg[idx] <= wr_word;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      a_rdata_reg <= '0;
      b_rdata_reg <= '0;
      a_ack_reg <= 1'b0;
      b_ack_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      a_rdata_reg <= a_rdata_next;
      b_rdata_reg <= b_rdata_next;
      a_ack_reg <= a_ack_next;
      b_ack_reg <= b_ack_next;
      busy_reg <= busy_next;
    end
  end

  assign a_rdata = a_rdata_reg;
  assign b_rdata = b_rdata_reg;
  assign a_ack = a_ack_reg;
  assign b_ack = b_ack_reg;
  assign refresh_busy = busy_reg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_ports_apart: assert property ( // [R1]
    !(a_ack_reg && b_ack_reg))
    else $error("both ports acknowledged together");
  a_b_goes_first: assert property ( // [R2]
    (state_reg == DPM_IDLE && !due_reg && pend_a && pend_b && !s_lock)
    |=> (sel_reg == DPM_PORT_B && state_reg == DPM_ACCESS && pend_a))
    else $error("port B not favoured");
  a_lock_holds_b: assert property ( // [R3]
    (state_reg == DPM_IDLE && !due_reg && s_lock && pend_b)
    |=> (state_reg != DPM_ACCESS || sel_reg == DPM_PORT_A))
    else $error("port B granted under lock");
  a_refresh_first: assert property ( // [R5]
    (state_reg == DPM_IDLE && due_reg) |=> state_reg == DPM_REFRESH)
    else $error("access taken before due refresh");
  a_refresh_served: assert property ( // [R6]
    $rose(due_reg) |-> ##[1:DUE_MAX] (state_reg == DPM_REFRESH))
    else $error("refresh left waiting");
  a_ack_timing: assert property ( // [R10]
    (state_reg == DPM_ACCESS && $past(state_reg) != DPM_ACCESS)
    |-> ##ACC_N (a_ack_reg || b_ack_reg))
    else $error("access cycle length wrong");
  a_parity_read: assert property ( // [R7]
    (a_ack_reg && PARITY_EN && !op_we_reg && $past(op_be_reg[0]))
    |-> a_rdata_reg[DATA_W] == ^a_rdata_reg[BYTE_W-1:0])
    else $error("read parity mismatch");
  a_byte_keep: assert property ( // [R8]
    (mem_we && !op_be_reg[1])
    |=> mem_cur[DATA_W-1:BYTE_W] == $past(mem_cur[DATA_W-1:BYTE_W]))
    else $error("unselected byte changed");
  a_pend_kept: assert property ( // [R14]
    (pend_a && !grant_a) |=> pend_a)
    else $error("pending request dropped");
  a_range_only: assert property ( // [R9]
    (a_ack_reg || b_ack_reg)
    |-> {1'b0, op_addr_reg} < (ADDR_W+1)'(DEPTH))
    else $error("access outside fitted capacity");

  c_contention: cover property (
    (pend_a && pend_b && state_reg == DPM_IDLE) ##[1:12] b_ack_reg);
  c_lock_grant: cover property (s_lock && grant_a && pend_b);
  c_refresh_then_access: cover property (
    state_reg == DPM_REFRESH ##1 state_reg == DPM_IDLE ##1
    state_reg == DPM_ACCESS);
  c_ecc_access: cover property (s_in[SI_ECC] && a_ack_reg);

endmodule

// ==== dpm_arbiter_tb.sv ====
// Purpose: self-checking bench for the dual-port memory arbiter
// Assumes: small depth and refresh period to keep the run short
// Notes: expected words come from a shadow copy kept by the bench
`timescale 1ns/100ps
module dpm_arbiter_tb;
  import dpm_pkg::*;
  localparam int DEP = 16384;
  localparam int REF = 40;
  localparam int RLIM = REF + ACCESS_CYC + REFRESH_CYC + 8;
  logic clk, srst, a_lock, ecc_mode, map_ext, ecc_refresh_req, bp_junk;
  logic a_req, b_req, a_we, b_we, a_ack, b_ack, refresh_busy, rb_q;
  logic [LANES-1:0] a_be, b_be;
  logic [ADDR_W-1:0] a_addr, b_addr;
  logic [DATA_W-1:0] a_wdata, b_wdata;
  logic [WORD_W-1:0] a_rdata, b_rdata;
  logic [DATA_W-1:0] shadow [int];
  logic [ADDR_W-1:0] pool [8];
  int n_mismatch, comparisons, gap, n_ref, n_ack;
  wire link = ecc_mode | map_ext;

  dpm_arbiter #(.DEPTH(DEP), .PARITY_EN(1'b1), .REFRESH_CYCLES(REF)) i_dut (
    .clk(clk), .srst(srst),
    .a_req_bp(link ? bp_junk : a_req), .a_req_link(link & a_req),
    .a_we(a_we), .a_be(a_be), .a_addr(a_addr), .a_wdata(a_wdata),
    .a_rdata(a_rdata), .a_ack(a_ack),
    .b_req_bp(link ? bp_junk : b_req), .b_req_link(link & b_req),
    .b_we(b_we), .b_be(b_be), .b_addr(b_addr), .b_wdata(b_wdata),
    .b_rdata(b_rdata), .b_ack(b_ack),
    .a_lock(a_lock), .ecc_mode(ecc_mode), .map_ext(map_ext),
    .ecc_refresh_req(ecc_refresh_req), .refresh_busy(refresh_busy)
  );
  dpm_req_model i_pa (.clk(clk), .ack(a_ack), .rdata(a_rdata), .req(a_req),
    .we(a_we), .be(a_be), .addr(a_addr), .wdata(a_wdata));
  dpm_req_model i_pb (.clk(clk), .ack(b_ack), .rdata(b_rdata), .req(b_req),
    .we(b_we), .be(b_be), .addr(b_addr), .wdata(b_wdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ************************************************************
  // checking helpers
  // ************************************************************
  task automatic chk_word(input logic [WORD_W-1:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  function automatic logic [WORD_W-1:0] exp_word(input logic [DATA_W-1:0] d);
    return {^d[15:8], ^d[7:0], d};
  endfunction

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic op(input bit pb, input logic w, input logic [1:0] b,
    input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d, input int dly,
    output int lat);
    logic [WORD_W-1:0] rd;
    bit got;
    if (pb) i_pb.access(w, b, ad, d, dly, 60, rd, lat, got);
    else i_pa.access(w, b, ad, d, dly, 60, rd, lat, got);
    chk_bit(got, 1'b1, "no ack");
    chk_bit(lat <= ACCESS_MAX_CYC, 1'b1, "ack too late");
    if (w) begin
      if (b[0]) shadow[ad][7:0] = d[7:0];
      if (b[1]) shadow[ad][15:8] = d[15:8];
    end else begin
      chk_word(rd, exp_word(shadow[ad]), "read word");
    end
  endtask

  // ************************************************************
  // refresh and precedence monitor
  // ************************************************************
  always @(posedge clk) begin
    if (refresh_busy === 1'b1) chk_bit(a_ack | b_ack, 1'b0, "ack in refresh");
    if (a_ack === 1'b1 || b_ack === 1'b1) n_ack <= n_ack + 1;
    if (refresh_busy === 1'b1 && rb_q !== 1'b1) n_ref <= n_ref + 1;
    if (srst || ecc_mode) begin
      gap <= 0;
    end else if (refresh_busy === 1'b1 && rb_q !== 1'b1) begin
      chk_bit(gap <= RLIM, 1'b1, "refresh late");
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
    rb_q <= refresh_busy;
  end

  // ************************************************************
  // watchdog, run needs under two thousand cycles
  // ************************************************************
  initial begin
    #500000;
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    give_verdict();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    int la, lb, k, m;
    logic [WORD_W-1:0] rd;
    bit got;
    void'($urandom(37));
    {srst, a_lock, ecc_mode, map_ext, ecc_refresh_req, bp_junk} = 6'h20;
    {n_mismatch, comparisons, n_ref, n_ack} = '0;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    // fill a pool holding both ends of the fitted range
    for (k = 0; k < 8; k++) begin
      pool[k] = k == 0 ? '0 : k == 1 ? ADDR_W'(DEP - 1)
        : ADDR_W'($urandom_range(DEP - 1));
      op(k[0], 1'b1, 2'h3, pool[k], DATA_W'($urandom), 0, la);
    end
    // random mix on both ports, prompt and slow, all byte enables
    for (k = 0; k < 60; k++) begin
      op($urandom_range(1), $urandom_range(1), 2'($urandom_range(3)),
        pool[$urandom_range(7)], DATA_W'($urandom), $urandom_range(3),
        la);
    end
    // simultaneous requests, without and with lockout
    for (k = 0; k < 2; k++) begin
      a_lock = k[0];
      repeat (4) @(negedge clk);
      fork
        op(1'b0, 1'b0, 2'h3, pool[0], 16'h0000, 0, la);
        op(1'b1, 1'b0, 2'h3, pool[1], 16'h0000, 0, lb);
        // lockout ends once port A is served, or port B would starve
        if (k) begin
          wait (a_ack === 1'b1);
          @(negedge clk);
          a_lock = 1'b0;
        end
      join
      chk_bit(k ? la < lb : lb < la, 1'b1, "port order");
    end
    a_lock = 1'b0;
    // just past the fitted range and at the top of the address space: never acked, must not alias
    i_pa.access(1'b1, 2'h3, ADDR_W'(DEP), 16'hA5A5, 0, 40, rd, la, got);
    chk_bit(got, 1'b0, "out of range acked");
    i_pb.access(1'b1, 2'h3, 16'hFFFF, 16'h5A5A, 0, 40, rd, la, got);
    chk_bit(got, 1'b0, "out of range acked");
    op(1'b0, 1'b0, 2'h3, pool[0], 16'h0000, 0, la);
    // map lines, then board mode with board-paced refresh
    for (k = 0; k < 2; k++) begin
      map_ext = !k[0];
      ecc_mode = k[0];
      repeat (6) @(negedge clk);
      m = n_ack;
      bp_junk = 1'b1;
      repeat (30) @(negedge clk);
      chk_bit(n_ack == m, 1'b1, "backplane not ignored");
      bp_junk = 1'b0;
      op(1'b0, 1'b1, 2'h2, pool[2], 16'h5AC3, 1, la);
      op(1'b1, 1'b0, 2'h3, pool[2], 16'h0000, 0, la);
      if (k) begin
        m = n_ref;
        repeat (100) @(negedge clk);
        chk_bit(n_ref == m, 1'b1, "refresh without board");
        ecc_refresh_req = 1'b1;
        repeat (4) @(negedge clk);
        ecc_refresh_req = 1'b0;
        repeat (16) @(negedge clk);
        chk_bit(n_ref == m + 1, 1'b1, "board refresh count");
      end
    end
    {map_ext, ecc_mode} = 2'h0;
    repeat (6) @(negedge clk);
    op(1'b1, 1'b0, 2'h3, pool[1], 16'h0000, 0, la);
    m = n_ref;
    repeat (2 * REF) @(negedge clk);
    chk_bit(n_ref > m, 1'b1, "internal refresh stopped");
    give_verdict();
  end
endmodule

// ==== dpm_pkg.sv ====
// Purpose: shared constants and types for the dual-port refreshed memory
// Assumes: 100 MHz clock, synchronous active-high reset
// Notes: the two limit cycle counts are derived from the printed times
package dpm_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CYCLE_MAX_NS = 660;
  localparam int ACCESS_MAX_NS = 560;
  // longest times round down
  localparam int CYCLE_MAX_CYC = CYCLE_MAX_NS / CLK_PERIOD_NS;
  localparam int ACCESS_MAX_CYC = ACCESS_MAX_NS / CLK_PERIOD_NS;
  // refresh interval is not printed; plain default
  localparam int REFRESH_PERIOD_NS = 15000;
  localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = 4;
  localparam int REFRESH_CYC = 4;
  localparam int TMR_W = 16;
  localparam int CNT_W = 8;

  // ************************************************************
  // word layout
  // ************************************************************
  localparam int BYTE_W = 8;
  localparam int LANES = 2;
  localparam int DATA_W = BYTE_W * LANES;
  localparam int PAR_W = LANES;
  localparam int WORD_W = DATA_W + PAR_W;
  localparam int ADDR_W = 16;
  localparam int FULL_WORDS = 65536;

  // ************************************************************
  // synchroniser bit positions
  // ************************************************************
  localparam int SYNC_W = 8;
  localparam int SI_A_BP = 0;
  localparam int SI_A_LINK = 1;
  localparam int SI_B_BP = 2;
  localparam int SI_B_LINK = 3;
  localparam int SI_LOCK = 4;
  localparam int SI_ECC = 5;
  localparam int SI_MAP = 6;
  localparam int SI_EREF = 7;

  typedef enum logic [1:0] {
    DPM_IDLE,
    DPM_ACCESS,
    DPM_REFRESH
  } dpm_state_t;

  typedef enum logic {
    DPM_PORT_A,
    DPM_PORT_B
  } dpm_port_t;

endpackage

// ==== dpm_port_req.sv ====
// Purpose: per-port pending request holder
// Assumes: req is already synchronised; address stable while req high
// Notes: a new request needs req to drop and rise again
`timescale 1ns/100ps
module dpm_port_req
  import dpm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic req,
  input wire logic addr_ok,
  input wire logic grant,
  output logic pending
);

  logic req_q_reg;
  logic req_q_next;
  logic pend_reg;
  logic pend_next;
  logic rise;

  always_comb begin
    rise = req & ~req_q_reg;
    req_q_next = req;
    // set wins over the grant clear; out-of-range requests never pend
    pend_next = (rise & addr_ok) | (pend_reg & ~grant); // [R14] [R9]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      req_q_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      req_q_reg <= req_q_next;
      pend_reg <= pend_next;
    end
  end

  assign pending = pend_reg;

endmodule

// ==== dpm_req_model.sv ====
// Purpose: requester model for one port of the dual-port memory
// Assumes: drives on the falling edge, samples ack on the rising edge
// Notes: released lines show the inverse of their last value
`timescale 1ns/100ps
module dpm_req_model
  import dpm_pkg::*;
(
  input wire logic clk,
  input wire logic ack,
  input wire logic [WORD_W-1:0] rdata,
  output logic req,
  output logic we,
  output logic [LANES-1:0] be,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] wdata
);
  initial begin
    req = 1'b0;
    we = 1'b0;
    be = 2'h0;
    addr = 16'h0000;
    wdata = 16'h0000;
  end

  // ************************************************************
  // one transfer, own set of lines per port
  // ************************************************************
  task automatic access(input logic w, input logic [LANES-1:0] b,
    input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd,
    input int dly, input int maxw, output logic [WORD_W-1:0] rd,
    output int lat, output bit got);
    lat = 0;
    got = 1'b0;
    rd = '0;
    repeat (dly) @(negedge clk);
    we = w;
    be = b;
    addr = ad;
    wdata = wd;
    req = 1'b1;
    // held until ack seen or maxw cycles pass, a lost arbitration must not drop it
    while (!got && lat < maxw) begin
      @(posedge clk);
      lat++;
      if (ack === 1'b1) begin
        got = 1'b1;
        rd = rdata;
      end
    end
    @(negedge clk);
    req = 1'b0;
    // stale values would hide a design sampling too late
    we = ~we;
    be = ~be;
    addr = ~addr;
    wdata = ~wdata;
    // low long enough for the synced level to fall
    repeat (3) @(negedge clk);
  endtask
endmodule

// ==== dpm_sync.sv ====
// Purpose: two-flop synchroniser for pin-level inputs
// Assumes: inputs are levels, not single-cycle pulses
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module dpm_sync
  import dpm_pkg::*;
#(
  parameter int WIDTH = SYNC_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = din;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg;

endmodule
